// >>> sssoc_pkg.sv
`default_nettype none
package sssoc_pkg;

  // ****************************************************
  // clock and time base
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_FREQ_KHZ  = 125000;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned HICCUP_MS     = 20;
  // valley sample window, least time so rounded up
  localparam int unsigned OC_SAMPLE_NS  = 75;
  localparam int unsigned OC_SAMPLE_CYCLES =
    (OC_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************
  // switching frequency and set pulse
  // ****************************************************
  localparam logic [10:0] FREQ_MIN_KHZ    = 11'h1f4;
  localparam logic [10:0] FREQ_MAX_KHZ    = 11'h5dc;
  localparam int unsigned SET_PULSE_SHIFT = 3;

  // ****************************************************
  // overload protection counts
  // ****************************************************
  localparam logic [3:0] OC_TOTAL_MAX = 4'h8;
  localparam logic [1:0] OC_RUN_DOWN  = 2'h3;
  localparam logic [2:0] OC_RUN_UP    = 3'h4;

  // ****************************************************
  // sequencing fields and telemetry
  // ****************************************************
  localparam logic [6:0] RAMP_MS_MIN     = 7'h01;
  localparam int unsigned IOUT_BYTE_SHIFT = 2;

  typedef enum logic [1:0] {
    SLEW_0P625, SLEW_1P25, SLEW_2P5, SLEW_5
  } sssoc_slew_e;
  localparam sssoc_slew_e SLEW_RESET = SLEW_2P5;

  typedef enum logic [1:0] {
    EN_PIN_ONLY, EN_SW_ONLY, EN_PIN_AND_SW
  } sssoc_enmode_e;

  typedef enum logic [1:0] {
    DUTY_NOMINAL, DUTY_HALF, DUTY_QUARTER, DUTY_EIGHTH
  } sssoc_duty_e;

endpackage
`default_nettype wire

// >>> sssoc_tick_gen.sv
`default_nettype none
module sssoc_tick_gen #(
  parameter int unsigned MS_CYC = sssoc_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [10:0] freq_khz,
  output logic             ms_tick,
  output logic             sw_tick,
  output logic             set_pulse,
  output logic             oc_sample,
  output logic [10:0]      freq_used
);
  if (MS_CYC < 2 || MS_CYC > 24'hffffff) begin : g_chk
    $error("sssoc_tick_gen: MS_CYC out of range");
  end

  typedef struct packed {
    logic [23:0] ms_cnt;
    logic [8:0]  sw_cnt;
    logic [10:0] freq;
    logic        ms_tick;
    logic        sw_tick;
    logic        set_pulse;
    logic        oc_sample;
  } sssoc_tick_s;

  sssoc_tick_s r;
  sssoc_tick_s next_r;
  logic [8:0]  period;

  // out-of-range settings are pulled to the nearest legal bound
  always_comb begin
    next_r = r;
    if (freq_khz < sssoc_pkg::FREQ_MIN_KHZ) begin
      next_r.freq = sssoc_pkg::FREQ_MIN_KHZ;
    end else if (freq_khz > sssoc_pkg::FREQ_MAX_KHZ) begin
      next_r.freq = sssoc_pkg::FREQ_MAX_KHZ;
    end else begin
      next_r.freq = freq_khz;
    end
    period = 9'(sssoc_pkg::CLK_FREQ_KHZ / r.freq);
    next_r.ms_tick = (r.ms_cnt == 24'(MS_CYC - 1));
    next_r.ms_cnt  = next_r.ms_tick ? 24'h000000 : r.ms_cnt + 24'h000001;
    next_r.sw_tick = (r.sw_cnt >= period - 9'h001);
    next_r.sw_cnt  = next_r.sw_tick ? 9'h000 : r.sw_cnt + 9'h001;
    // set pulse is the first eighth of each period
    next_r.set_pulse = (next_r.sw_cnt < (period >> sssoc_pkg::SET_PULSE_SHIFT));
    // one strobe per period, 10 cycles (80 ns) after the set pulse rises
    next_r.oc_sample = (next_r.sw_cnt == 9'(sssoc_pkg::OC_SAMPLE_CYCLES));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{freq: sssoc_pkg::FREQ_MIN_KHZ, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign ms_tick   = r.ms_tick;
  assign sw_tick   = r.sw_tick;
  assign set_pulse = r.set_pulse;
  assign oc_sample = r.oc_sample;
  assign freq_used = r.freq;
endmodule
`default_nettype wire

// >>> sssoc_ocp_ctrl.sv
`default_nettype none
module sssoc_ocp_ctrl (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       sample,
  input  wire logic       trip,
  input  wire logic       duty_low,
  output logic [1:0]      duty_code,
  output logic            fault
);
  typedef struct packed {
    logic [3:0] total;
    logic [1:0] run_hi;
    logic [2:0] run_lo;
    logic [1:0] duty;
    logic       no_reduce;
    logic       fault;
  } sssoc_ocp_s;

  sssoc_ocp_s r;
  sssoc_ocp_s next_r;

  // counters move only on the once-per-period sample strobe
  always_comb begin
    next_r = r;
    next_r.fault = 1'b0;
    if (clear) begin
      next_r = '0;                                       // see RULE_23
    end else if (sample && trip) begin
      if (r.duty == 2'(sssoc_pkg::DUTY_NOMINAL)) begin
        next_r.no_reduce = duty_low;                     // see RULE_22
      end
      next_r.total  = r.total + 4'h1;
      next_r.run_lo = 3'h0;
      next_r.run_hi = r.run_hi + 2'h1;
      if (next_r.run_hi == sssoc_pkg::OC_RUN_DOWN) begin
        next_r.run_hi = 2'h0;
        if (!next_r.no_reduce && r.duty != 2'(sssoc_pkg::DUTY_EIGHTH)) begin
          next_r.duty = r.duty + 2'h1;                   // see RULE_20
        end
      end
      next_r.fault = (next_r.total == sssoc_pkg::OC_TOTAL_MAX); // see RULE_19
    end else if (sample) begin
      next_r.run_hi = 2'h0;
      next_r.run_lo = r.run_lo + 3'h1;
      if (next_r.run_lo == sssoc_pkg::OC_RUN_UP) begin
        next_r.run_lo = 3'h0;
        if (r.duty != 2'(sssoc_pkg::DUTY_NOMINAL)) begin
          next_r.duty = r.duty - 2'h1;                   // see RULE_21
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign duty_code = r.duty;
  assign fault     = r.fault;
endmodule
`default_nettype wire

// >>> sssoc_sequencer.sv
//
// Contract
// RULE_01: ramp starts only with enable, bus above lockout, config copied in.
// RULE_02: software enable may replace or accompany the hardware enable.
// RULE_03: bus mode delays ramp start 0 to 127 ms, 1 ms steps.
// RULE_04: bus mode ramp duration 1 to 127 ms, 1 ms steps.
// RULE_05: vid mode slew selectable among four rates, 2.5 after reset.
// RULE_06: vid mode zero boot holds output until a set command arrives.
// RULE_07: overload and overvoltage protection stay armed during the ramp.
// RULE_08: switching frequency accepted from 500 kHz to 1.5 MHz.
// RULE_09: by default enable low turns both drivers off at once.
// RULE_10: optional shutdown by operation bit and optional controlled ramp down.
// RULE_11: bus mode soft-off waits a 0 to 127 ms turn-off delay.
// RULE_12: bus mode ramp-down duration 1 to 127 ms, 1 ms steps.
// RULE_13: average current reported in sixteenths of an ampere.
// RULE_14: current also given as an 8-bit byte in quarter amperes.
// RULE_15: warning when average current exceeds the warning threshold.
// RULE_16: overload sampled 75 ns after set pulse rise, set pulse an eighth.
// RULE_17: eight tripped cycles drop internal enable 20 ms, then restart.
// RULE_18: overload limit accepted, host should use 16 to 56 A in 4 A.
// RULE_19: after eight limiting cycles, either latch off or hiccup.
// RULE_20: three consecutive trips halve duty limit down to one eighth.
// RULE_21: four consecutive clear cycles double duty limit back to nominal.
// RULE_22: no duty reduction if already below one eighth at onset.
// RULE_23: counters step once a period and clear on hiccup end or re-enable.
`default_nettype none
module sssoc_sequencer #(
  parameter int unsigned MS_CYC = sssoc_pkg::MS_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        EN_ABOVE_THRESH,
  input  wire logic        BUS_ABOVE_UVLO,
  input  wire logic        CFG_LOADED,
  input  wire logic [1:0]  EN_MODE,
  input  wire logic        SW_ENABLE,
  input  wire logic        BUS_MODE,
  input  wire logic        SOFT_OFF,
  input  wire logic [6:0]  TON_DELAY_MS,
  input  wire logic [6:0]  TON_RISE_MS,
  input  wire logic [6:0]  TOFF_DELAY_MS,
  input  wire logic [6:0]  TOFF_FALL_MS,
  input  wire logic        SLEW_WR,
  input  wire logic [1:0]  SLEW_SEL,
  input  wire logic        VID_BOOT_ZERO,
  input  wire logic        VID_SET_CMD,
  input  wire logic        VID_TARGET_REACHED,
  input  wire logic [10:0] FREQ_KHZ,
  input  wire logic        OC_TRIP,
  input  wire logic        OC_RESP_LATCH,
  input  wire logic        DUTY_BELOW_EIGHTH,
  input  wire logic [7:0]  IOUT_OC_FAULT_LIMIT,
  input  wire logic [15:0] IOUT_AVG,
  input  wire logic [15:0] IOUT_OC_WARN_LIMIT,
  output logic             DRIVERS_ON,
  output logic             PROTECT_ARMED,
  output logic             REF_RAMP_UP,
  output logic             REF_RAMP_DOWN,
  output logic [6:0]       RAMP_MS,
  output logic [1:0]       SLEW_CODE,
  output logic             HICCUP_ACTIVE,
  output logic             OC_LATCHED,
  output logic [7:0]       OC_LIMIT,
  output logic [1:0]       DUTY_LIMIT,
  output logic             SET_PULSE,
  output logic             OC_SAMPLE,
  output logic [10:0]      FREQ_USED,
  output logic [15:0]      READ_IOUT,
  output logic [7:0]       LOAD_CURRENT_TELEMETRY_BYTE,
  output logic             OC_WARN
);

  // ****************************************************
  // types and state
  // ****************************************************
  typedef enum logic [2:0] {
    ST_OFF,
    ST_TON_WAIT,
    ST_RAMP_UP,
    ST_ON,
    ST_TOFF_WAIT,
    ST_RAMP_DOWN,
    ST_HICCUP,
    ST_LATCHED
  } sssoc_state_e;

  // bit 0 enable pin, bit 1 bus lockout, bit 2 overload trip
  typedef struct packed {
    sssoc_state_e         state;
    logic [2:0]           sync1;
    logic [2:0]           sync2;
    logic [6:0]           ms_cnt;
    sssoc_pkg::sssoc_slew_e slew;
    logic                 drv_on;
    logic                 armed;
    logic                 ramp_up;
    logic                 ramp_down;
    logic                 hiccup;
    logic                 latched;
    logic                 ocp_clear;
    logic [7:0]           oc_limit;
    logic [15:0]          iout;
    logic [7:0]           iout_byte;
    logic                 oc_warn;
  } sssoc_seq_s;

  sssoc_seq_s r;
  sssoc_seq_s next_r;

  logic       ms_tick;
  logic       sw_tick;
  logic       set_pulse;
  logic       oc_sample;
  logic [10:0] freq_used;
  logic [1:0] duty_code;
  logic       oc_fault;
  logic       conv_en;
  logic       en_pin;
  logic       bus_ok;
  logic       oc_trip;

  // ****************************************************
  // helper functions
  // ****************************************************
  // a ramp of zero would end at once, so it is raised to 1 ms
  function automatic logic [6:0] ramp_len(input logic [6:0] ms);
    ramp_len = (ms < sssoc_pkg::RAMP_MS_MIN) ? sssoc_pkg::RAMP_MS_MIN : ms;
  endfunction

  // combines pin and software enables as the mode selects
  function automatic logic en_combine(input logic [1:0] mode,
                                      input logic       pin,
                                      input logic       sw);
    unique case (mode)
      2'(sssoc_pkg::EN_PIN_ONLY): begin
        en_combine = pin;
      end
      2'(sssoc_pkg::EN_SW_ONLY): begin
        en_combine = sw;
      end
      default: begin
        en_combine = pin & sw;   // code 3 treated as both, the safe reading
      end
    endcase
  endfunction

  // ****************************************************
  // sub blocks
  // ****************************************************
  // period timing and the 80 ns sample strobe live here
  sssoc_tick_gen #(
    .MS_CYC (MS_CYC)
  ) u_tick (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .freq_khz  (FREQ_KHZ),     // see RULE_08
    .ms_tick   (ms_tick),
    .sw_tick   (sw_tick),
    .set_pulse (set_pulse),
    .oc_sample (oc_sample),    // see RULE_16
    .freq_used (freq_used)
  );

  // overload counting runs whenever the drivers switch
  sssoc_ocp_ctrl u_ocp (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .clear     (r.ocp_clear),
    .sample    (oc_sample & r.drv_on),
    .trip      (oc_trip),
    .duty_low  (DUTY_BELOW_EIGHTH),
    .duty_code (duty_code),
    .fault     (oc_fault)
  );

  // ****************************************************
  // enable qualification
  // ****************************************************
  // only the second synchroniser stage is read
  assign en_pin  = r.sync2[0];
  assign bus_ok  = r.sync2[1];
  assign oc_trip = r.sync2[2];

  // config loaded comes from on-chip logic, so no synchroniser
  assign conv_en = CFG_LOADED & bus_ok                     // see RULE_01
                 & en_combine(EN_MODE, en_pin, SW_ENABLE); // see RULE_02

  // ****************************************************
  // sequencer next state
  // ****************************************************
  always_comb begin
    next_r = r;
    next_r.sync1     = {OC_TRIP, BUS_ABOVE_UVLO, EN_ABOVE_THRESH};
    next_r.sync2     = r.sync1;
    next_r.ocp_clear = 1'b0;
    if (ms_tick) begin
      next_r.ms_cnt = r.ms_cnt + 7'h01;
    end
    // slew select is only loaded by the write strobe
    if (SLEW_WR) begin
      next_r.slew = sssoc_pkg::sssoc_slew_e'(SLEW_SEL);   // see RULE_05
    end
    next_r.oc_limit = IOUT_OC_FAULT_LIMIT;                 // see RULE_18
    unique case (r.state)
      ST_OFF: begin
        if (conv_en) begin
          next_r.state     = ST_TON_WAIT;
          next_r.ms_cnt    = 7'h00;
          next_r.ocp_clear = 1'b1;                         // see RULE_23
        end
      end
      ST_TON_WAIT: begin
        if (!conv_en) begin
          next_r.state = ST_OFF;
        end else if (BUS_MODE) begin
          // zero delay passes straight through
          if (r.ms_cnt >= TON_DELAY_MS) begin              // see RULE_03
            next_r.state  = ST_RAMP_UP;
            next_r.ms_cnt = 7'h00;
          end
        end else if (!VID_BOOT_ZERO || VID_SET_CMD) begin  // see RULE_06
          next_r.state  = ST_RAMP_UP;
          next_r.ms_cnt = 7'h00;
        end
      end
      ST_RAMP_UP: begin
        if (!conv_en) begin
          next_r.state = ST_OFF;
        end else if (BUS_MODE ? (r.ms_cnt >= ramp_len(TON_RISE_MS))
                              : VID_TARGET_REACHED) begin  // see RULE_04
          next_r.state = ST_ON;
        end
      end
      ST_ON: begin
        if (!conv_en && SOFT_OFF) begin                    // see RULE_10
          next_r.ms_cnt = 7'h00;
          // turn-off delay is a bus-mode feature only
          next_r.state  = BUS_MODE ? ST_TOFF_WAIT          // see RULE_11
                                   : ST_RAMP_DOWN;
        end else if (!conv_en) begin
          next_r.state = ST_OFF;                           // see RULE_09
        end
      end
      ST_TOFF_WAIT: begin
        if (r.ms_cnt >= TOFF_DELAY_MS) begin
          next_r.state  = ST_RAMP_DOWN;
          next_r.ms_cnt = 7'h00;
        end
      end
      ST_RAMP_DOWN: begin
        if (r.ms_cnt >= ramp_len(TOFF_FALL_MS)) begin      // see RULE_12
          next_r.state = ST_OFF;
        end
      end
      ST_HICCUP: begin
        // internal enable held low for the hiccup time
        if (r.ms_cnt >= 7'(sssoc_pkg::HICCUP_MS)) begin    // see RULE_17
          next_r.state     = ST_OFF;
          next_r.ocp_clear = 1'b1;                         // see RULE_23
        end
      end
      ST_LATCHED: begin
        // only a full disable releases a latched shutdown
        if (!conv_en) begin
          next_r.state     = ST_OFF;
          next_r.ocp_clear = 1'b1;
        end
      end
    endcase
    // the fault can only be raised while switching, so it wins here
    if (oc_fault && r.drv_on) begin
      next_r.ms_cnt = 7'h00;
      next_r.state  = OC_RESP_LATCH ? ST_LATCHED           // see RULE_19
                                    : ST_HICCUP;           // see RULE_17
    end
    // registered driver and ramp flags follow the next state
    next_r.drv_on    = (next_r.state == ST_RAMP_UP)
                     | (next_r.state == ST_ON)
                     | (next_r.state == ST_TOFF_WAIT)
                     | (next_r.state == ST_RAMP_DOWN);
    next_r.armed     = next_r.drv_on;                      // see RULE_07
    next_r.ramp_up   = (next_r.state == ST_RAMP_UP);
    next_r.ramp_down = (next_r.state == ST_RAMP_DOWN);
    next_r.hiccup    = (next_r.state == ST_HICCUP);
    next_r.latched   = (next_r.state == ST_LATCHED);
  end

  // ****************************************************
  // telemetry
  // ****************************************************
  // the byte saturates instead of wrapping on large currents
  logic [13:0] quarter_amps;
  assign quarter_amps = IOUT_AVG[15:sssoc_pkg::IOUT_BYTE_SHIFT];

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      r <= '{state: ST_OFF, slew: sssoc_pkg::SLEW_RESET, default: '0};
    end else begin
      r <= next_r;
      r.iout <= IOUT_AVG;                                  // see RULE_13
      r.iout_byte <= (quarter_amps > 14'h00ff) ? 8'hff     // see RULE_14
                                               : quarter_amps[7:0];
      r.oc_warn <= (IOUT_AVG > IOUT_OC_WARN_LIMIT);        // see RULE_15
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign DRIVERS_ON    = r.drv_on;
  assign PROTECT_ARMED = r.armed;
  assign REF_RAMP_UP   = r.ramp_up;
  assign REF_RAMP_DOWN = r.ramp_down;
  assign RAMP_MS       = r.ms_cnt;
  assign SLEW_CODE     = r.slew;
  assign HICCUP_ACTIVE = r.hiccup;
  assign OC_LATCHED    = r.latched;
  assign OC_LIMIT      = r.oc_limit;
  assign DUTY_LIMIT    = duty_code;                        // see RULE_20
  assign SET_PULSE     = set_pulse;
  assign OC_SAMPLE     = oc_sample;
  assign FREQ_USED     = freq_used;
  assign READ_IOUT     = r.iout;
  assign LOAD_CURRENT_TELEMETRY_BYTE = r.iout_byte;
  assign OC_WARN       = r.oc_warn;

endmodule
`default_nettype wire

// >>> sssoc_props.sv
`default_nettype none
module sssoc_props #(
  parameter int unsigned MS_CYC = sssoc_pkg::MS_CYCLES
) (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        EN_ABOVE_THRESH,
  input wire logic        CFG_LOADED,
  input wire logic [1:0]  EN_MODE,
  input wire logic        SOFT_OFF,
  input wire logic        SLEW_WR,
  input wire logic [1:0]  SLEW_SEL,
  input wire logic [15:0] IOUT_AVG,
  input wire logic [15:0] IOUT_OC_WARN_LIMIT,
  input wire logic        DRIVERS_ON,
  input wire logic        PROTECT_ARMED,
  input wire logic        REF_RAMP_UP,
  input wire logic [1:0]  SLEW_CODE,
  input wire logic        HICCUP_ACTIVE,
  input wire logic        OC_LATCHED,
  input wire logic        SET_PULSE,
  input wire logic        OC_SAMPLE,
  input wire logic [10:0] FREQ_USED,
  input wire logic [15:0] READ_IOUT,
  input wire logic [7:0]  LOAD_CURRENT_TELEMETRY_BYTE,
  input wire logic        OC_WARN
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // hiccup length; ms ticks run free so the first one may come early
  // ****
  int unsigned hic_cnt;
  always_ff @(posedge CORE_CLK) hic_cnt <= HICCUP_ACTIVE ? hic_cnt + 1 : 0;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  AST_START: assert property ($rose(DRIVERS_ON) |-> $past(CFG_LOADED))
    else $error("drivers on without loaded config");
  AST_SLEW: assert property (SLEW_WR |-> ##1 SLEW_CODE == $past(SLEW_SEL))
    else $error("slew code not loaded");
  AST_ARMED: assert property (REF_RAMP_UP && $past(REF_RAMP_UP) |-> PROTECT_ARMED)
    else $error("protection off during ramp");
  AST_FREQ: assert property (FREQ_USED >= 11'h1f4 && FREQ_USED <= 11'h5dc)
    else $error("frequency out of range");
  AST_OFF: assert property ($fell(EN_ABOVE_THRESH) && DRIVERS_ON && !SOFT_OFF
    && EN_MODE != 2'h1 |-> ##[1:6] !DRIVERS_ON) else $error("slow hard off");
  AST_IOUT: assert property (!$past(RESET) |-> READ_IOUT == $past(IOUT_AVG))
    else $error("current report wrong");
  AST_BYTE: assert property (!$past(RESET) |-> LOAD_CURRENT_TELEMETRY_BYTE ==
    ((|$past(IOUT_AVG[15:10])) ? 8'hff : $past(IOUT_AVG[9:2])))
    else $error("telemetry byte wrong");
  AST_WARN: assert property (!$past(RESET) |->
    OC_WARN == ($past(IOUT_AVG) > $past(IOUT_OC_WARN_LIMIT)))
    else $error("warning flag wrong");
  AST_SAMPLE: assert property ($rose(SET_PULSE) |-> ##[1:12] OC_SAMPLE)
    else $error("no sample after set pulse");
  AST_HICCUP: assert property ($fell(HICCUP_ACTIVE) |->
    hic_cnt >= 19 * MS_CYC + 2 && hic_cnt <= 20 * MS_CYC + 1)
    else $error("hiccup length");
  AST_LATCH: assert property (OC_LATCHED |-> !DRIVERS_ON && !HICCUP_ACTIVE)
    else $error("latched with drivers on");
endmodule
bind sssoc_sequencer sssoc_props #(.MS_CYC(MS_CYC)) i_sssoc_props (.*);
`default_nettype wire

// >>> sssoc_vid_host.sv
`default_nettype none
module sssoc_vid_host #(
  parameter int DLY = 40
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        ramp_up,
  output logic             set_cmd,
  output logic             target_reached,
  output logic [10:0]      freq_khz,
  output logic [7:0]       oc_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // ****
  // host programming, offset frequency and a 4 A step limit
  // ****
  assign freq_khz = 11'h1f9;
  assign oc_limit = 8'h28;
  initial begin
    set_cmd = 1'b0;
    target_reached = 1'b0;
  end
  // one set command per request; target reached after a slow settle
  always @(negedge clk) begin
    set_cmd <= req & ~rst;
    cnt <= ramp_up ? cnt + 1 : 0;
    target_reached <= ramp_up && cnt >= DLY - 1;
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MSC = 10;
  logic        CORE_CLK = 1'b0, RESET = 1'b1, vreq = 1'b0;
  logic        EN_ABOVE_THRESH, BUS_ABOVE_UVLO, CFG_LOADED, SW_ENABLE;
  logic        BUS_MODE, SOFT_OFF, SLEW_WR, VID_BOOT_ZERO, OC_TRIP;
  logic        OC_RESP_LATCH, DUTY_BELOW_EIGHTH, VID_SET_CMD;
  logic        VID_TARGET_REACHED, DRIVERS_ON, PROTECT_ARMED, OC_WARN;
  logic        REF_RAMP_UP, REF_RAMP_DOWN, HICCUP_ACTIVE, OC_LATCHED;
  logic        SET_PULSE, OC_SAMPLE;
  logic [1:0]  EN_MODE, SLEW_SEL, SLEW_CODE, DUTY_LIMIT;
  logic [6:0]  TON_DELAY_MS, TON_RISE_MS, TOFF_DELAY_MS, TOFF_FALL_MS, RAMP_MS;
  logic [7:0]  IOUT_OC_FAULT_LIMIT, OC_LIMIT, LOAD_CURRENT_TELEMETRY_BYTE;
  logic [10:0] FREQ_KHZ, FREQ_USED;
  logic [15:0] IOUT_AVG, IOUT_OC_WARN_LIMIT, READ_IOUT;
  int          miscompares = 0, cmp_count = 0, cyc = 0, n;
  wire logic [4:0] obs = {REF_RAMP_DOWN, HICCUP_ACTIVE, OC_LATCHED,
                          REF_RAMP_UP, DRIVERS_ON};

  sssoc_sequencer #(.MS_CYC(MSC)) i_sssoc_sequencer (.*);
  sssoc_vid_host #(.DLY(40)) i_sssoc_vid_host (.clk(CORE_CLK), .rst(RESET),
    .req(vreq), .ramp_up(REF_RAMP_UP), .set_cmd(VID_SET_CMD),
    .target_reached(VID_TARGET_REACHED), .freq_khz(FREQ_KHZ),
    .oc_limit(IOUT_OC_FAULT_LIMIT));

  // ****
  // clock, timeout and shared helpers
  // ****
  always #4 CORE_CLK = ~CORE_CLK;
  // a hang costs a mismatch rather than a silent stall
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // waits for one observed flag, counting cycles
  task automatic wt(input int b, input logic v, output int k);
    k = 0;
    while (obs[b] !== v && k < 3000) begin
      @(negedge CORE_CLK);
      k++;
    end
  endtask
  // trip level set just after a sample so no sample sees it half synced
  task automatic samp(input logic t, input int k);
    OC_TRIP = t;
    repeat (k) begin
      @(negedge CORE_CLK);
      while (OC_SAMPLE !== 1'b1) @(negedge CORE_CLK);
    end
    repeat (4) @(negedge CORE_CLK);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset();
    chk(SLEW_CODE === 2'h2, "slew after reset");
    chk(DRIVERS_ON === 1'b0, "drivers after reset");
    for (int s = 0; s < 4; s++) begin
      SLEW_SEL = s[1:0];
      SLEW_WR = 1'b1;
      @(negedge CORE_CLK);
      SLEW_WR = 1'b0;
      repeat (2) @(negedge CORE_CLK);
      chk(SLEW_CODE === s[1:0], "slew select");
    end
    $display("test reset finished");
  endtask
  task automatic t_telem();
    logic [15:0] v[4] = '{16'h0040, 16'h03ff, 16'h0400, 16'hffff};
    foreach (v[i]) begin
      IOUT_AVG = v[i];
      repeat (2) @(negedge CORE_CLK);
      chk(READ_IOUT === v[i], "current");
      chk(LOAD_CURRENT_TELEMETRY_BYTE === ((|v[i][15:10]) ? 8'hff : v[i][9:2]), "byte");
      chk(OC_WARN === (v[i] > IOUT_OC_WARN_LIMIT), "warn");
    end
    $display("test telemetry finished");
  endtask
  task automatic t_start();
    EN_ABOVE_THRESH = 1'b1;
    BUS_ABOVE_UVLO = 1'b1;
    repeat (60) @(negedge CORE_CLK);
    chk(DRIVERS_ON === 1'b0, "on without config");
    CFG_LOADED = 1'b1;
    wt(0, 1'b1, n);
    chk(n >= 20 && n <= 45, "turn-on delay");
    chk(PROTECT_ARMED === 1'b1 && REF_RAMP_UP === 1'b1, "armed");
    wt(1, 1'b0, n);
    chk(n >= 15 && n <= 25 && RAMP_MS === 7'h02, "rise time");
    chk(FREQ_USED === 11'h1f9 && OC_LIMIT === 8'h28, "settings");
    EN_ABOVE_THRESH = 1'b0;
    wt(0, 1'b0, n);
    chk(n <= 6 && REF_RAMP_DOWN === 1'b0, "hard off");
    $display("test start finished");
  endtask
  task automatic t_soft();
    EN_MODE = 2'h1;
    SOFT_OFF = 1'b1;
    TON_DELAY_MS = 7'h00;
    TOFF_DELAY_MS = 7'h02;
    SW_ENABLE = 1'b1;
    wt(0, 1'b1, n);
    chk(n <= 15, "software start, no delay");
    wt(1, 1'b0, n);
    SW_ENABLE = 1'b0;
    wt(4, 1'b1, n);
    chk(n >= 10 && n <= 30, "turn-off delay");
    chk(DRIVERS_ON === 1'b1, "drivers in soft off");
    wt(4, 1'b0, n);
    chk(n >= 25 && n <= 35 && DRIVERS_ON === 1'b0, "fall time");
    EN_MODE = 2'h0;
    SOFT_OFF = 1'b0;
    $display("test soft off finished");
  endtask
  task automatic t_ocp();
    EN_ABOVE_THRESH = 1'b1;
    wt(1, 1'b1, n);
    wt(1, 1'b0, n);
    samp(1'b0, 1);
    samp(1'b1, 6);
    chk(DUTY_LIMIT === 2'h2, "duty after six trips");
    samp(1'b1, 2);
    chk(HICCUP_ACTIVE === 1'b1 && DRIVERS_ON === 1'b0, "hiccup");
    OC_TRIP = 1'b0;
    wt(3, 1'b0, n);
    chk(n >= 180 && n <= 210, "hiccup length");
    wt(1, 1'b1, n);
    wt(1, 1'b0, n);
    chk(DRIVERS_ON === 1'b1 && DUTY_LIMIT === 2'h0, "restart");
    samp(1'b0, 1);
    samp(1'b1, 3);
    chk(DUTY_LIMIT === 2'h1, "halved");
    samp(1'b0, 4);
    chk(DUTY_LIMIT === 2'h0, "restored");
    DUTY_BELOW_EIGHTH = 1'b1;
    OC_RESP_LATCH = 1'b1;
    samp(1'b1, 4);
    chk(DUTY_LIMIT === 2'h0 && OC_LATCHED === 1'b0, "low duty");
    samp(1'b1, 1);
    chk(OC_LATCHED === 1'b1 && DRIVERS_ON === 1'b0, "latched");
    OC_TRIP = 1'b0;
    EN_ABOVE_THRESH = 1'b0;
    wt(2, 1'b0, n);
    chk(n <= 10, "latch release");
    $display("test overload finished");
  endtask
  task automatic t_vid();
    BUS_MODE = 1'b0;
    VID_BOOT_ZERO = 1'b1;
    DUTY_BELOW_EIGHTH = 1'b0;
    EN_ABOVE_THRESH = 1'b1;
    repeat (60) @(negedge CORE_CLK);
    chk(REF_RAMP_UP === 1'b0, "zero boot held");
    vreq <= 1'b1;
    @(negedge CORE_CLK);
    vreq <= 1'b0;
    wt(1, 1'b1, n);
    chk(n <= 6, "ramp on set command");
    wt(1, 1'b0, n);
    chk(n >= 38 && n <= 46, "ramp to target");
    $display("test vid finished");
  endtask

  // stimulus starts from known levels at time zero
  initial begin
    {EN_ABOVE_THRESH, BUS_ABOVE_UVLO, CFG_LOADED, SW_ENABLE, SOFT_OFF} = '0;
    {SLEW_WR, VID_BOOT_ZERO, OC_TRIP, OC_RESP_LATCH, DUTY_BELOW_EIGHTH} = '0;
    {EN_MODE, SLEW_SEL} = '0;
    BUS_MODE = 1'b1;
    {TON_DELAY_MS, TON_RISE_MS, TOFF_DELAY_MS, TOFF_FALL_MS} = {4{7'h03}};
    TON_RISE_MS = 7'h02;
    IOUT_AVG = 16'h0000;
    IOUT_OC_WARN_LIMIT = 16'h03ff;
    repeat (2) @(negedge CORE_CLK);
    RESET = 1'b0;
    t_reset();
    t_telem();
    t_start();
    t_soft();
    t_ocp();
    t_vid();
    report_and_stop();
  end
endmodule
`default_nettype wire
